/* File: rtl/mpio_gpio.sv */
// multipurpose output pin selectors and gpio port with apb slave
//
// The implementer's own choice: the APB register port.
`timescale 1ns/100ps
module mpio_gpio
  import mpio_gpio_pkg::*;
(
  // clock and reset
  input  wire logic                mclk,
  input  wire logic                resetn,
  // apb slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  input  wire logic [3:0]          pstrb,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  // internal sources, codes 0011 upward in order
  input  wire logic [NUM_SRC-1:0]  route_src,
  // dedicated output pins
  output logic                     dedicated_out_pin_one_out,
  output logic                     dedicated_out_pin_one_oe,
  output logic                     dedicated_out_pin_zero_out,
  output logic                     dedicated_out_pin_zero_oe,
  // io pins: a at 3:0, b at 7:4, c at 11:8
  input  wire logic [NUM_IO-1:0]   io_pin_in,
  output logic      [NUM_IO-1:0]   io_pin_out,
  output logic      [NUM_IO-1:0]   io_pin_oe,
  // alternate function drive when a group is not gpio
  input  wire logic [NUM_IO-1:0]   alt_io_out,
  input  wire logic [NUM_IO-1:0]   alt_io_oe
);

  // register state
  logic [7:0]        source_sel_q;
  logic [7:0]        ab_dir_q;
  logic [3:0]        c_dir_q;
  logic [7:0]        ab_out_q;
  logic [3:0]        c_out_q;
  logic [2:0]        assign_q;
  logic [NUM_IO-1:0] sync1_q;
  logic [NUM_IO-1:0] sync2_q;
  logic [31:0]       prdata_q;
  logic              pready_q;
  logic              pslverr_q;
  logic              out_one_q;
  logic              oe_one_q;
  logic              out_zero_q;
  logic              oe_zero_q;
  logic [NUM_IO-1:0] io_out_q;
  logic [NUM_IO-1:0] io_oe_q;

  // address decode
  wire logic [6:0]  idx_w      = paddr[8:2];
  wire logic        addr_ok_w  = (paddr[1:0] == 2'b00) && (paddr[11:9] == 3'b000);
  wire logic        setup_w    = psel && !penable;
  wire logic        wr_w       = psel && penable && pready_q && pwrite && !pslverr_q
                                 && pstrb[0];
  wire logic        hit_w      = addr_ok_w && (idx_w >= IDX_SOURCE_SEL)
                                 && (idx_w <= IDX_GPIO_ASSIGN);
  // read only registers refuse writes
  wire logic        ro_w       = (idx_w == IDX_AB_IN) || (idx_w == IDX_C_IN);
  wire logic        err_d      = !hit_w || (pwrite && ro_w);

  // group masks: each gpio bit covers its four pins
  wire logic [NUM_IO-1:0] gmask_w = {{4{assign_q[2]}}, {4{assign_q[1]}}, {4{assign_q[0]}}};
  wire logic [NUM_IO-1:0] dir_w   = {c_dir_q, ab_dir_q};
  wire logic [NUM_IO-1:0] oval_w  = {c_out_q, ab_out_q};
  // sensed levels read zero while the group is not gpio
  wire logic [NUM_IO-1:0] in_w    = sync2_q & gmask_w;

  // read mux; reserved upper bits read zero
  logic [7:0] rd_w;
  always_comb begin
    rd_w = 8'h00;
    unique case (idx_w)
      IDX_SOURCE_SEL:  rd_w = source_sel_q;
      IDX_AB_DIR:      rd_w = ab_dir_q;
      IDX_C_DIR:       rd_w = {4'h0, c_dir_q};
      IDX_AB_OUT:      rd_w = ab_out_q;
      IDX_C_OUT:       rd_w = {4'h0, c_out_q};
      IDX_AB_IN:       rd_w = in_w[7:0];
      IDX_C_IN:        rd_w = {4'h0, in_w[11:8]};
      IDX_GPIO_ASSIGN: rd_w = {5'h00, assign_q};
      default:         rd_w = 8'h00;
    endcase
  end

  // apb answer: one wait-free access phase after every setup
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= setup_w;
      pslverr_q <= setup_w && err_d;
      prdata_q  <= (setup_w && !pwrite && !err_d) ? {24'h00_0000, rd_w} : 32'h0000_0000;
    end
  end

  // register writes take effect at the access edge
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      source_sel_q <= {RST_SEL_ONE, RST_SEL_ZERO};
      ab_dir_q     <= RST_AB;
      c_dir_q      <= RST_C;
      ab_out_q     <= RST_AB;
      c_out_q      <= RST_C;
      assign_q     <= RST_ASSIGN;
    end else if (wr_w) begin
      if (idx_w == IDX_SOURCE_SEL)  source_sel_q <= pwdata[7:0];
      if (idx_w == IDX_AB_DIR)      ab_dir_q     <= pwdata[7:0];
      if (idx_w == IDX_C_DIR)       c_dir_q      <= pwdata[3:0];
      if (idx_w == IDX_AB_OUT)      ab_out_q     <= pwdata[7:0];
      if (idx_w == IDX_C_OUT)       c_out_q      <= pwdata[3:0];
      if (idx_w == IDX_GPIO_ASSIGN) assign_q     <= pwdata[2:0];
    end
  end

  // two flops before any logic sees a pin
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= io_pin_in;
      sync2_q <= sync1_q;
    end
  end

  // selector decode for the dedicated pins
  wire logic [3:0] sel_one_w  = source_sel_q[SEL_ONE_LSB +: 4];
  wire logic [3:0] sel_zero_w = source_sel_q[SEL_ZERO_LSB +: 4];
  wire logic [3:0] src_one_w  = sel_one_w - SEL_FIRST_SRC;
  wire logic [3:0] src_zero_w = sel_zero_w - SEL_FIRST_SRC;
  wire logic       rt_one_w   = route_src[src_one_w];
  wire logic       rt_zero_w  = route_src[src_zero_w];
  wire logic       oe_one_d   = (sel_one_w != SEL_HIZ);
  wire logic       oe_zero_d  = (sel_zero_w != SEL_HIZ);
  wire logic       out_one_d  = (sel_one_w == SEL_CONST_HI) ? 1'b1 :
                                (sel_one_w == SEL_CONST_LO) ? 1'b0 :
                                (sel_one_w >= SEL_FIRST_SRC) && rt_one_w;
  wire logic       out_zero_d = (sel_zero_w == SEL_CONST_HI) ? 1'b1 :
                                (sel_zero_w == SEL_CONST_LO) ? 1'b0 :
                                (sel_zero_w >= SEL_FIRST_SRC) && rt_zero_w;

  // gpio pins; output data only reaches a pin that drives
  wire logic [NUM_IO-1:0] io_oe_d  = (gmask_w & dir_w) | (~gmask_w & alt_io_oe);
  wire logic [NUM_IO-1:0] io_out_d = (gmask_w & dir_w & oval_w)
                                     | (~gmask_w & alt_io_out);

  // registered pin drive costs one cycle of latency on routed sources
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      out_one_q  <= 1'b0;
      oe_one_q   <= 1'b0;
      out_zero_q <= 1'b0;
      oe_zero_q  <= 1'b0;
      io_out_q   <= '0;
      io_oe_q    <= '0;
    end else begin
      out_one_q  <= out_one_d;
      oe_one_q   <= oe_one_d;
      out_zero_q <= out_zero_d;
      oe_zero_q  <= oe_zero_d;
      io_out_q   <= io_out_d;
      io_oe_q    <= io_oe_d;
    end
  end

  // outputs straight from flops
  assign prdata                     = prdata_q;
  assign pready                     = pready_q;
  assign pslverr                    = pslverr_q;
  assign dedicated_out_pin_one_out  = out_one_q;
  assign dedicated_out_pin_one_oe   = oe_one_q;
  assign dedicated_out_pin_zero_out = out_zero_q;
  assign dedicated_out_pin_zero_oe  = oe_zero_q;
  assign io_pin_out                 = io_out_q;
  assign io_pin_oe                  = io_oe_q;

  // checks on pin drive, input sync and reserved read bits
  property p_one_hiz;
    @(posedge mclk) disable iff (!resetn)
    (sel_one_w == SEL_HIZ) |=> !dedicated_out_pin_one_oe;
  endproperty
  a_one_hiz: assert property (p_one_hiz) else $error("pin one not released");

  property p_one_route;
    @(posedge mclk) disable iff (!resetn)
    (sel_one_w >= SEL_FIRST_SRC) |=> dedicated_out_pin_one_oe
      && (dedicated_out_pin_one_out == $past(route_src[sel_one_w - SEL_FIRST_SRC]));
  endproperty
  a_one_route: assert property (p_one_route) else $error("pin one wrong source");

  property p_zero_route;
    @(posedge mclk) disable iff (!resetn)
    (sel_zero_w == 4'hD) |=> (dedicated_out_pin_zero_out == $past(route_src[10]));
  endproperty
  a_zero_route: assert property (p_zero_route) else $error("pin zero wrong source");

  property p_const_hi;
    @(posedge mclk) disable iff (!resetn)
    (sel_zero_w == 4'h1) |=> dedicated_out_pin_zero_oe && dedicated_out_pin_zero_out;
  endproperty
  a_const_hi: assert property (p_const_hi) else $error("constant high missing");

  property p_const_lo;
    @(posedge mclk) disable iff (!resetn)
    (sel_one_w == 4'h2) |=> dedicated_out_pin_one_oe && !dedicated_out_pin_one_out;
  endproperty
  a_const_lo: assert property (p_const_lo) else $error("constant low missing");

  property p_gpio_drive;
    @(posedge mclk) disable iff (!resetn)
    1'b1 |=> ((io_pin_oe & $past(gmask_w)) == $past(dir_w & gmask_w))
      && ((io_pin_out & $past(gmask_w)) == $past(dir_w & oval_w & gmask_w));
  endproperty
  a_gpio_drive: assert property (p_gpio_drive) else $error("gpio drive wrong");

  property p_alt_drive;
    @(posedge mclk) disable iff (!resetn)
    (assign_q == 3'h0) |=> (io_pin_oe == $past(alt_io_oe));
  endproperty
  a_alt_drive: assert property (p_alt_drive) else $error("alt drive lost");

  property p_input_sync;
    @(posedge mclk) disable iff (!resetn)
    $stable(assign_q) |-> (in_w == ($past(io_pin_in, 2) & gmask_w));
  endproperty
  a_input_sync: assert property (p_input_sync) else $error("input level wrong");

  property p_rsv_zero;
    @(posedge mclk) disable iff (!resetn)
    (setup_w && !pwrite && (idx_w == IDX_C_DIR)) |=> (prdata[7:4] == 4'h0) && pready;
  endproperty
  a_rsv_zero: assert property (p_rsv_zero) else $error("reserved bits set");

endmodule : mpio_gpio

/* File: rtl/mpio_gpio_pkg.sv */
// constants for the multipurpose pin and gpio control block
// Function
// - pin one selector: hi-z, constants, thirteen sources
// - pin zero selector same map, resets 1101
// - code 0001 drives constant high
// - code 0010 drives constant low
// - a/b direction: b at 7:4, a 3:0
// - direction bit 0 input, 1 output
// - c direction bits 3:0, upper read zero
// - gpio settings act only when group assigned
// - direction selectable per pin
// - a/b output data: b 7:4, a 3:0
// - output bit 0 drives low, 1 high
// - output bit acts only when pin outputs
// - c output data bits 3:0, upper reserved
// - a/b input data read only, sensed levels
// - c input data read only, bits 3:0
// - input bit reads sensed pin level; code reads zero while its group is not gpio
// - both selectors share one register, one high
package mpio_gpio_pkg;
  // register indices; byte address is four times the index
  localparam logic [6:0] IDX_SOURCE_SEL  = 7'h78;
  localparam logic [6:0] IDX_AB_DIR      = 7'h79;
  localparam logic [6:0] IDX_C_DIR       = 7'h7A;
  localparam logic [6:0] IDX_AB_OUT      = 7'h7B;
  localparam logic [6:0] IDX_C_OUT       = 7'h7C;
  localparam logic [6:0] IDX_AB_IN       = 7'h7D;
  localparam logic [6:0] IDX_C_IN        = 7'h7E;
  localparam logic [6:0] IDX_GPIO_ASSIGN = 7'h7F;
  // reset values
  localparam logic [3:0] RST_SEL_ONE  = 4'h3;
  localparam logic [3:0] RST_SEL_ZERO = 4'hD;
  localparam logic [7:0] RST_AB       = 8'h00;
  localparam logic [3:0] RST_C        = 4'h0;
  localparam logic [2:0] RST_ASSIGN   = 3'h0;
  // selector codes
  localparam logic [3:0] SEL_HIZ       = 4'h0;
  localparam logic [3:0] SEL_CONST_HI  = 4'h1;
  localparam logic [3:0] SEL_CONST_LO  = 4'h2;
  localparam logic [3:0] SEL_FIRST_SRC = 4'h3;
  // field positions and sizes
  localparam int SEL_ONE_LSB  = 4;
  localparam int SEL_ZERO_LSB = 0;
  localparam int NUM_SRC      = 13;
  localparam int NUM_IO       = 12;
endpackage : mpio_gpio_pkg

/* File: dv/mpio_gpio_tb.sv */
// self-checking bench for the multipurpose pin and gpio block
`timescale 1ns/100ps
module mpio_gpio_tb;
  import mpio_gpio_pkg::*;
  // stimulus and observed signals
  logic        mclk, resetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr, io_pin_in, io_pin_out, io_pin_oe, alt_io_out, alt_io_oe;
  logic [31:0] pwdata, prdata, d;
  logic [3:0]  pstrb, c;
  logic [12:0] src;
  logic        o1, e1, o0, e0, er;
  int          failures, n_tests, cyc;
  // gpio step table: assign, ab dir, ab out, c dir, c out
  logic [2:0]  t_asg[4] = '{3'h0, 3'h1, 3'h7, 3'h6};
  logic [7:0]  t_dab[4] = '{8'hFF, 8'h5A, 8'h5A, 8'hA5};
  logic [7:0]  t_oab[4] = '{8'hFF, 8'hF0, 8'h0F, 8'h33};
  logic [3:0]  t_dc[4]  = '{4'hF, 4'h3, 4'h3, 4'hC};
  logic [3:0]  t_oc[4]  = '{4'hF, 4'h6, 4'h6, 4'h9};

  mpio_gpio dut (.mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .route_src(src), .dedicated_out_pin_one_out(o1),
    .dedicated_out_pin_one_oe(e1), .dedicated_out_pin_zero_out(o0),
    .dedicated_out_pin_zero_oe(e0), .io_pin_in(io_pin_in), .io_pin_out(io_pin_out),
    .io_pin_oe(io_pin_oe), .alt_io_out(alt_io_out), .alt_io_oe(alt_io_oe));

  // 100 MHz clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // hang guard, well above the expected few hundred cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      final_report();
    end
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : final_report

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      failures++;
    end
  endtask : chk

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [6:0] idx, input logic [31:0] wd);
    int n;
    @(posedge mclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= {3'h0, idx, 2'h0}; pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    // pready, prdata and pslverr are taken at the edge that samples pready high
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      $display("[FAIL] pready expected 1 seen %b", pready);
      failures++;
    end
    d = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [6:0] idx, input logic [7:0] v, input logic ee);
    apb(1'b1, idx, {24'h0, v});
    chk("write pslverr", ee, er);
  endtask : wr

  task automatic rd(input logic [6:0] idx, input logic [7:0] v, input logic ee);
    apb(1'b0, idx, 32'h0);
    chk("read pslverr", ee, er);
    chk("prdata", ee ? 32'h0 : {24'h0, v}, d);
  endtask : rd

  // {oe, out} expected on a dedicated pin for a selector code
  function automatic logic [1:0] pexp(input logic [3:0] k, input logic [12:0] s);
    if (k == SEL_HIZ) return 2'b00;
    if (k == SEL_CONST_HI) return 2'b11;
    if (k == SEL_CONST_LO) return 2'b10;
    return {1'b1, s[k - 4'h3]};
  endfunction : pexp

  task automatic pins(input logic [2:0] a, input logic [11:0] dr, input logic [11:0] ov);
    logic [11:0] eo, ev;
    for (int g = 0; g < 3; g++) begin
      eo[g*4+:4] = a[g] ? dr[g*4+:4] : alt_io_oe[g*4+:4];
      ev[g*4+:4] = a[g] ? ov[g*4+:4] : alt_io_out[g*4+:4];
    end
    chk("io_pin_oe", eo, io_pin_oe);
    chk("io_pin_out", ev & eo, io_pin_out & io_pin_oe);
  endtask : pins

  // main sequence
  initial begin
    resetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
    pwdata = 32'h0; pstrb = 4'hF; src = 13'h1555; io_pin_in = 12'h000;
    alt_io_out = 12'h5A5; alt_io_oe = 12'h3C6;
    repeat (10) @(posedge mclk);
    resetn <= 1'b1;
    repeat (2) @(posedge mclk);
    chk("pin one", pexp(4'h3, src), {e1, o1 & e1});
    chk("pin zero", pexp(4'hD, src), {e0, o0 & e0});
    rd(IDX_SOURCE_SEL, 8'h3D, 1'b0);
    rd(IDX_AB_DIR, 8'h00, 1'b0);
    rd(IDX_C_DIR, 8'h00, 1'b0);
    rd(IDX_AB_OUT, 8'h00, 1'b0);
    rd(IDX_C_OUT, 8'h00, 1'b0);
    // every selector code on both pins, two source patterns
    for (int k = 0; k < 32; k++) begin
      c = k[3:0];
      src <= k[4] ? 13'h0AAA : 13'h1555;
      wr(IDX_SOURCE_SEL, {c, ~c}, 1'b0);
      repeat (2) @(posedge mclk);
      chk("pin one", pexp(c, src), {e1, o1 & e1});
      chk("pin zero", pexp(~c, src), {e0, o0 & e0});
    end
    // gpio steps, group assignment varied
    for (int s = 0; s < 4; s++) begin
      wr(IDX_GPIO_ASSIGN, {5'h0, t_asg[s]}, 1'b0);
      wr(IDX_AB_DIR, t_dab[s], 1'b0);
      wr(IDX_C_DIR, {4'hF, t_dc[s]}, 1'b0);
      wr(IDX_AB_OUT, t_oab[s], 1'b0);
      wr(IDX_C_OUT, {4'hF, t_oc[s]}, 1'b0);
      rd(IDX_C_DIR, {4'h0, t_dc[s]}, 1'b0);
      rd(IDX_C_OUT, {4'h0, t_oc[s]}, 1'b0);
      io_pin_in <= {t_oc[s], t_dab[s] ^ 8'h3C};
      repeat (2) @(posedge mclk);
      pins(t_asg[s], {t_dc[s], t_dab[s]}, {t_oc[s], t_oab[s]});
      repeat (3) @(posedge mclk);
      rd(IDX_AB_IN, (t_dab[s] ^ 8'h3C) & {{4{t_asg[s][1]}}, {4{t_asg[s][0]}}}, 1'b0);
      rd(IDX_C_IN, {4'h0, t_oc[s] & {4{t_asg[s][2]}}}, 1'b0);
    end
    // refused accesses: read-only and unmapped places
    wr(IDX_AB_IN, 8'hFF, 1'b1);
    wr(IDX_C_IN, 8'hFF, 1'b1);
    rd(7'h10, 8'h00, 1'b1);
    // a write without its low byte strobe is dropped without error
    pstrb <= 4'hE;
    wr(IDX_AB_DIR, 8'h00, 1'b0);
    pstrb <= 4'hF;
    rd(IDX_AB_DIR, 8'hA5, 1'b0);
    final_report();
  end
endmodule : mpio_gpio_tb
